/* rtl/ast_baud_gen.sv */
// baud tick divider, 8 or 16 bit wide
`timescale 1ns/10ps
module ast_baud_gen #(
    parameter int WIDTH = 16
) (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic             run,
    input  wire logic             wide,
    input  wire logic [WIDTH-1:0] divisor,
    output logic                  tick
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] limit;

    // narrow mode uses only the low byte of the divisor
    assign limit = wide ? divisor : {{(WIDTH-8){1'b0}}, divisor[7:0]};

    // restart on run so the first bit gets a full period
    always_ff @(posedge clock) begin
        if (sys_rst || !run) begin
            count_reg <= '0;
            tick      <= 1'b0;
        end else if (count_reg >= limit) begin
            count_reg <= '0;
            tick      <= 1'b1;
        end else begin
            count_reg <= count_reg + 1'b1;
            tick      <= 1'b0;
        end
    end
endmodule

/* rtl/ast_pkg.sv */
// constants, register map and field layout of the async serial transmitter
package ast_pkg;
    // word byte addresses on the wishbone slave
    localparam logic [3:0] ADDR_TX_CTRL  = 4'h0;
    localparam logic [3:0] ADDR_RX_CTRL  = 4'h4;
    localparam logic [3:0] ADDR_BAUD_CTL = 4'h8;
    localparam logic [3:0] ADDR_BRG_LO   = 4'hC;
    localparam logic [3:0] ADDR_BRG_HI   = 4'h0;
    localparam logic [3:0] ADDR_TX_BUF   = 4'h4;
    localparam logic [1:0] PAGE_LOW      = 2'h0;
    localparam logic [1:0] PAGE_HIGH     = 2'h1;
    // tx_control_status fields
    localparam int TXC_NINTH_BIT  = 0;
    localparam int TXC_SHIFT_EMPTY = 1;
    localparam int TXC_SYNC       = 4;
    localparam int TXC_ENABLE     = 5;
    localparam int TXC_NINE_SEL   = 6;
    localparam int TXC_BUF_EMPTY  = 7;
    // rx_control_status fields
    localparam int RXC_PORT_EN    = 7;
    // baud_control fields
    localparam int BDC_WIDE       = 3;
    localparam int BDC_INVERT     = 4;
    // reset values
    localparam logic [7:0] TXC_RESET = 8'h02;
    localparam logic [7:0] BRG_RESET = 8'h00;
    // timing: one instruction cycle is four system clocks
    localparam int CLK_HZ         = 50_000_000;
    localparam int TCY_CLOCKS     = 4;
    localparam int FRAME_BITS_MAX = 11;
    localparam logic [3:0] BITS_EIGHT = 4'hA;
    localparam logic [3:0] BITS_NINE  = 4'hB;
endpackage

/* rtl/ast_shifter.sv */
// transmit shift register, frames one character lsb first
`timescale 1ns/10ps
module ast_shifter (
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic       load,
    input  wire logic [8:0] data,
    input  wire logic       nine,
    input  wire logic       tick,
    output logic            busy,
    output logic            line,
    output logic            stop_done
);
    logic [10:0] frame_reg;
    logic [3:0]  left_reg;

    // start at space, data lsb first, stop at mark; no parity
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            frame_reg <= '1;
            left_reg  <= 4'h0;
            busy      <= 1'b0;
            stop_done <= 1'b0;
        end else if (load) begin
            // ninth bit is msb when selected
            frame_reg <= nine ? {1'b1, data, 1'b0} : {2'b11, data[7:0], 1'b0};
            left_reg  <= nine ? ast_pkg::BITS_NINE : ast_pkg::BITS_EIGHT;
            busy      <= 1'b1;
            stop_done <= 1'b0;
        end else if (busy && tick) begin
            frame_reg <= {1'b1, frame_reg[10:1]};
            left_reg  <= left_reg - 4'h1;
            busy      <= (left_reg != 4'h1);
            stop_done <= (left_reg == 4'h1);
        end else begin
            stop_done <= 1'b0;
        end
    end

    // idle leaves line at mark
    assign line = busy ? frame_reg[0] : 1'b1;
endmodule

/* rtl/ast_tx_top.sv */
// async serial transmitter with classic wishbone register slave
`timescale 1ns/10ps
module ast_tx_top #(
    parameter int BRG_WIDTH = 16
) (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [4:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        tx_pin_i,
    output logic             tx_pin_o,
    output logic             tx_pin_oe,
    output logic             rx_pin_oe,
    output logic             gpio_tx_free,
    output logic             tx_active
);
    logic [7:0] tx_ctrl_reg;
    logic       port_enable_reg;
    logic       invert_reg;
    logic       wide_reg;
    logic [7:0] brg_lo_reg;
    logic [7:0] brg_hi_reg;
    logic [8:0] hold_reg;
    logic       hold_full_reg;
    logic       flag_delay_reg;
    logic [1:0] tcy_cnt_reg;
    logic       tx_enable;
    logic       async_run;
    logic       bus_req;
    logic       wr_lane0;
    logic       buf_write;
    logic       load;
    logic       busy;
    logic       line;
    logic       tick;
    logic       tcy_edge;
    logic       pend_reg;

    // decode one register slot from a word address
    function automatic logic hit(input logic [4:0] adr, input logic [1:0] page, input logic [3:0] off);
        hit = ({1'b0, adr[4]} == page) && (adr[3:0] == off);
    endfunction

    assign tx_enable = tx_ctrl_reg[ast_pkg::TXC_ENABLE];
    // async mode needs enable, sync clear, port on
    assign async_run = tx_enable && !tx_ctrl_reg[ast_pkg::TXC_SYNC] && port_enable_reg;
    assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // writes land at the edge where the master sees ack
    assign wr_lane0  = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
    // tx buffer lives at byte offset 4 (word 1) of the high page, apart from the divisor
    assign buf_write = wr_lane0 && hit(wb_adr_i, ast_pkg::PAGE_HIGH, ast_pkg::ADDR_TX_BUF);

    // single cycle answer, ack drops the next cycle
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // control registers; status bits are read-only
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tx_ctrl_reg     <= ast_pkg::TXC_RESET;
            port_enable_reg <= 1'b0;
            invert_reg      <= 1'b0;
            wide_reg        <= 1'b0;
            brg_lo_reg      <= ast_pkg::BRG_RESET;
            brg_hi_reg      <= ast_pkg::BRG_RESET;
        end else if (wr_lane0) begin
            unique case (wb_adr_i)
                5'h00: begin
                    tx_ctrl_reg[ast_pkg::TXC_NINTH_BIT] <= wb_dat_i[ast_pkg::TXC_NINTH_BIT];
                    tx_ctrl_reg[ast_pkg::TXC_SYNC]      <= wb_dat_i[ast_pkg::TXC_SYNC];
                    tx_ctrl_reg[ast_pkg::TXC_ENABLE]    <= wb_dat_i[ast_pkg::TXC_ENABLE];
                    tx_ctrl_reg[ast_pkg::TXC_NINE_SEL]  <= wb_dat_i[ast_pkg::TXC_NINE_SEL];
                end
                5'h04: port_enable_reg <= wb_dat_i[ast_pkg::RXC_PORT_EN];
                5'h08: begin
                    invert_reg <= wb_dat_i[ast_pkg::BDC_INVERT];
                    wide_reg   <= wb_dat_i[ast_pkg::BDC_WIDE];
                end
                5'h0C: brg_lo_reg <= wb_dat_i[7:0];
                5'h10: brg_hi_reg <= wb_dat_i[7:0];
                default: ;
            endcase
        end
    end

    // instruction cycle divider: queued transfers wait for a tcy edge
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tcy_cnt_reg <= 2'h0;
        end else begin
            tcy_cnt_reg <= tcy_cnt_reg + 2'h1;
        end
    end
    assign tcy_edge = (tcy_cnt_reg == 2'(ast_pkg::TCY_CLOCKS - 1));

    // holding buffer; only path into the shifter
    always_ff @(posedge clock) begin
        if (sys_rst || !async_run) begin
            hold_reg      <= '0;
            hold_full_reg <= 1'b0;
        end else if (buf_write) begin
            hold_reg      <= {tx_ctrl_reg[ast_pkg::TXC_NINTH_BIT], wb_dat_i[7:0]};
            hold_full_reg <= 1'b1;
        end else if (load) begin
            hold_full_reg <= 1'b0;
        end
    end

    // char queued behind a busy shifter moves on the next tcy edge
    always_ff @(posedge clock) begin
        if (sys_rst || !async_run || load) begin
            pend_reg <= 1'b0;
        end else if (hold_full_reg && busy) begin
            pend_reg <= 1'b1;
        end
    end
    // idle shifter takes the char at once; a queued one waits at most one tcy
    assign load = hold_full_reg && !busy && (!pend_reg || tcy_edge);

    // empty flag falls with a write, but rises one cycle after the buffer empties
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            flag_delay_reg <= 1'b0;
        end else begin
            flag_delay_reg <= tx_enable && !hold_full_reg && !buf_write;
        end
    end

    ast_baud_gen #(
        .WIDTH(BRG_WIDTH)
    ) u_baud (
        .clock  (clock),
        .sys_rst(sys_rst),
        .run    (busy),
        .wide   (wide_reg),
        .divisor(BRG_WIDTH'({brg_hi_reg, brg_lo_reg})),
        .tick   (tick)
    );

    ast_shifter u_shift (
        .clock    (clock),
        .sys_rst  (sys_rst || !async_run),
        .load     (load),
        .data     (hold_reg),
        .nine     (tx_ctrl_reg[ast_pkg::TXC_NINE_SEL]),
        .tick     (tick),
        .busy     (busy),
        .line     (line),
        .stop_done()
    );

    // status read back; baud format shared with receiver
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wb_dat_o <= '0;
        end else if (bus_req && !wb_we_i) begin
            wb_dat_o <= '0;
            unique case (wb_adr_i)
                5'h00: wb_dat_o[7:0] <= {flag_delay_reg, tx_ctrl_reg[6:2], !busy, tx_ctrl_reg[0]};
                5'h04: wb_dat_o[ast_pkg::RXC_PORT_EN] <= port_enable_reg;
                5'h08: wb_dat_o[7:0] <= {3'b000, invert_reg, wide_reg, 3'b000};
                5'h0C: wb_dat_o[7:0] <= brg_lo_reg;
                5'h10: wb_dat_o[7:0] <= brg_hi_reg;
                default: wb_dat_o <= '0;
            endcase
        end
    end

    // pin driven whenever the port and transmitter are on
    assign tx_pin_oe    = port_enable_reg && tx_enable;
    assign rx_pin_oe    = 1'b0;
    assign gpio_tx_free = !tx_pin_oe;
    // polarity applies only in async mode
    assign tx_pin_o     = tx_pin_oe ? (line ^ (invert_reg && !tx_ctrl_reg[ast_pkg::TXC_SYNC])) : tx_pin_i;
    assign tx_active    = busy;
endmodule

/* tb/ast_rx_model.sv */
// behavioural far-end receiver sampling mid-bit
`timescale 1ns/10ps
module ast_rx_model (
    input  wire logic        clock,
    input  wire logic        listen,
    input  wire logic        line,
    input  wire logic        inv,
    input  wire logic        nine,
    input  wire logic [16:0] bit_clocks,
    output logic [8:0]       rx_data,
    output logic [7:0]       rx_count,
    output logic             frame_err
);
    initial begin
        rx_count = 8'h00;
        frame_err = 1'b0;
        rx_data = 9'h000;
    end
    always begin
        @(posedge clock iff (listen && (line ^ inv) == 1'b0));
        repeat (bit_clocks / 2) @(posedge clock);
        if ((line ^ inv) !== 1'b0) frame_err = 1'b1;
        rx_data = 9'h000;
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
            repeat (bit_clocks) @(posedge clock);
            rx_data[i] = line ^ inv;
        end
        repeat (bit_clocks) @(posedge clock);
        if ((line ^ inv) !== 1'b1) frame_err = 1'b1;
        rx_count = rx_count + 8'h01;
    end
endmodule

/* tb/ast_tx_sva.sv */
// port checker for the async serial transmitter
`timescale 1ns/10ps
module ast_tx_sva (
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        tx_pin_i,
    input wire logic        tx_pin_o,
    input wire logic        tx_pin_oe,
    input wire logic        rx_pin_oe,
    input wire logic        gpio_tx_free,
    input wire logic        tx_active
);
    logic [15:0] run_reg;
    // saturates so a stuck busy flag never wraps to a small count
    always_ff @(posedge clock) begin
        if (sys_rst || !tx_active) begin
            run_reg <= 16'h0000;
        end else if (run_reg != 16'hFFFF) begin
            run_reg <= run_reg + 16'h0001;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    chk_ack_one: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_ack_resp: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    chk_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    chk_free_pair: assert property (gpio_tx_free == !tx_pin_oe)
        else $error("free flag disagrees with enable");
    chk_rx_release: assert property (!rx_pin_oe)
        else $error("receive pin driven");
    chk_pin_pass: assert property (!tx_pin_oe |-> tx_pin_o == tx_pin_i)
        else $error("released pin not passed through");
    chk_idle_hold: assert property (tx_pin_oe && $past(tx_pin_oe) && !tx_active && !$past(tx_active)
        && !$past(wb_ack_o) && !$past(wb_ack_o, 2) |-> $stable(tx_pin_o))
        else $error("idle line moved");
    chk_start_bit: assert property ($rose(tx_active) && tx_pin_oe
        |-> ##[0:1] (tx_pin_o != $past(tx_pin_o, 4)))
        else $error("no start bit after load");
    chk_frame_len: assert property ($fell(tx_active) |-> run_reg >= 16'h000A)
        else $error("frame shorter than ten bits");
    cover property ($rose(tx_active));
    cover property (tx_active && wb_ack_o);
    cover property ($fell(tx_pin_oe));
endmodule

bind ast_tx_top ast_tx_sva u_sva (.*);

/* tb/testbench.sv */
// self-checking bench for the async serial transmitter
`timescale 1ns/10ps
module testbench;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic        pin_i = 1'b0;
    logic        lsn = 1'b0;
    logic        inv = 1'b0;
    logic        nine = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic [7:0]  dat = 8'h00;
    logic [16:0] bclk = 17'h00101;
    logic [31:0] q;
    logic [31:0] dat_o;
    logic        ack, pin_o, oe, rx_oe, free, act, ferr;
    logic [8:0]  rx_d;
    logic [7:0]  rx_n;
    logic [7:0]  c;
    int          fail_count = 0;
    int          checked = 0;
    int          seed = 32'h97bc;
    always #10 clock = ~clock;
    ast_tx_top u_dut (.clock(clock), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i({24'h000000, dat}), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .tx_pin_i(pin_i), .tx_pin_o(pin_o), .tx_pin_oe(oe), .rx_pin_oe(rx_oe), .gpio_tx_free(free),
        .tx_active(act));
    ast_rx_model u_rx (.clock(clock), .listen(lsn && oe), .line(pin_o), .inv(inv), .nine(nine),
        .bit_clocks(bclk), .rx_data(rx_d), .rx_count(rx_n), .frame_err(ferr));
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        @(posedge clock);
        while (ack !== 1'b1) begin
            n++;
            if (n > 20) begin
                fail_count++;
                tally_and_finish();
            end
            @(posedge clock);
        end
        q = dat_o;
        cyc <= 1'b0;
        @(posedge clock);
    endtask
    // buffer sits apart from the divisor, so the bit time stays put
    task automatic send(input logic [7:0] ch);
        bus(5'h14, 1'b1, ch);
    endtask
    task automatic wait_rx(input logic [7:0] k);
        int n;
        n = 0;
        while (rx_n !== k || act !== 1'b0) begin
            n++;
            if (n > 20000) begin
                fail_count++;
                tally_and_finish();
            end
            @(posedge clock);
        end
    endtask
    function automatic logic [31:0] ctrl_exp(input logic [7:0] wr, input logic bufe, input logic shfe);
        return {24'h000000, (wr & 8'h71) | {bufe, 5'h00, shfe, 1'b0}};
    endfunction
    initial begin
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        bus(5'h00, 1'b0, 8'h00);
        cmp("ctrl reset", 32'h00000002, q);
        for (int i = 0; i < 4; i++) begin
            pin_i <= 1'($random(seed));
            @(posedge clock);
            cmp("pin pass", {31'h0, pin_i}, {31'h0, pin_o});
        end
        bus(5'h14, 1'b1, 8'hFF);
        bus(5'h14, 1'b0, 8'h00);
        cmp("unmapped", 32'h00000000, q);
        bus(5'h08, 1'b1, 8'h08);
        bus(5'h10, 1'b1, 8'h01);
        bus(5'h04, 1'b1, 8'h80);
        bus(5'h00, 1'b1, 8'h20);
        cmp("tx oe", 32'h1, {31'h0, oe});
        cmp("idle mark", 32'h1, {31'h0, pin_o});
        bus(5'h00, 1'b0, 8'h00);
        cmp("ctrl on", ctrl_exp(8'h20, 1'b1, 1'b1), q);
        lsn <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            c = 8'($random(seed));
            send(c);
            repeat (2 * ast_pkg::TCY_CLOCKS) @(posedge clock);
            bus(5'h00, 1'b0, 8'h00);
            cmp("shift busy", ctrl_exp(8'h20, 1'b1, 1'b0), q);
            wait_rx(8'(i + 1));
            cmp("char", {24'h0, c}, {23'h0, rx_d});
        end
        send(c);
        send(c);
        repeat (2 * ast_pkg::TCY_CLOCKS) @(posedge clock);
        bus(5'h00, 1'b0, 8'h00);
        cmp("buf held", ctrl_exp(8'h20, 1'b0, 1'b0), q);
        wait_rx(8'h05);
        cmp("queued char", {24'h0, c}, {23'h0, rx_d});
        cmp("idle after", 32'h1, {31'h0, pin_o});
        nine <= 1'b1;
        bus(5'h00, 1'b1, 8'h61);
        send(c);
        wait_rx(8'h06);
        cmp("nine bit", {23'h0, 1'b1, c}, {23'h0, rx_d});
        lsn <= 1'b0;
        bus(5'h08, 1'b1, 8'h18);
        inv <= 1'b1;
        cmp("inv idle", 32'h0, {31'h0, pin_o});
        bus(5'h00, 1'b1, 8'h20);
        nine <= 1'b0;
        lsn <= 1'b1;
        send(c);
        wait_rx(8'h07);
        cmp("inv char", {24'h0, c}, {23'h0, rx_d});
        lsn <= 1'b0;
        bus(5'h08, 1'b1, 8'h00);
        inv <= 1'b0;
        bus(5'h0C, 1'b1, c | 8'h40);
        bclk = 17'h00001 + {9'h000, c | 8'h40};
        lsn <= 1'b1;
        send(c);
        wait_rx(8'h08);
        cmp("narrow char", {24'h0, c}, {23'h0, rx_d});
        bus(5'h00, 1'b1, 8'h00);
        cmp("released", 32'h1, {31'h0, free});
        cmp("framing", 32'h0, {31'h0, ferr});
        tally_and_finish();
    end
endmodule
